// file: rtl/cpu_mode_defs.svh
`ifndef CPU_MODE_DEFS_SVH
`define CPU_MODE_DEFS_SVH
// core register indices
`define IDX_HIGH_FIRST 4'h8
`define IDX_HIGH_LAST  4'hc
`define IDX_SP         4'hd
`define IDX_LR         4'he
`define IDX_PC         4'hf
// alignment masks
`define SP_ALIGN_MASK  32'hffff_fffc
`define PC_ALIGN_MASK  32'hffff_fffe
// status word field masks
`define APP_MASK       32'hf800_0000
`define IRQ_MASK       32'h0000_01ff
`define EXEC_MASK      32'h0700_fc00
`define EXEC_STATE_BIT 24
`define FLAG_LSB       27
`define FLAG_MSB       31
// mode select fields
`define MODE_USER_BIT  0
`define MODE_PSTK_BIT  1
// bit-band geometry
`define BB_SRAM_BASE   32'h2000_0000
`define BB_ALIAS_BASE  32'h2200_0000
`define BB_ALIAS_SPAN  32'h0200_0000
`define BB_WORD_SHIFT  5
`define BB_BIT_LSB     2
// reset values
`define THRESH_RST     9'h000
`define MODE_RST       2'h0
`define IRQ_NUM_NONE   9'h000
`endif

// file: rtl/cpu_mode_pkg.sv
package cpu_mode_pkg;
  typedef logic [31:0] word_t;
  // special register selector for move-to / move-from operations
  typedef enum logic [2:0] {
    sel_combined,
    sel_app,
    sel_irq,
    sel_exec,
    sel_gen_mask,
    sel_fault_mask,
    sel_threshold,
    sel_mode
  } sys_sel_e;
endpackage

// file: rtl/cpu_mode_and_core_regs.sv
// What this block does
// - three states only; never user handler
// - user mask/threshold/mode/exec writes blocked; any access to them faults
// - exceptions run privileged handler, else thread
// - banked stack: process for user thread
// - stack pointer low two bits zero
// - program counter bit zero forced zero
// - subroutine call writes return address link
// - app flags in bits 27-31; views selectable
// - active exception number in bits 0-8
// - exec state bits; privileged write of bit 24 clear faults
// - general mask passes only nmi, hard fault
// - fault mask passes only nmi
// - threshold blocks equal/higher value; zero off
// - mode bit 0 selects thread level
// - narrow instructions cannot reach regs 8-12
// - sixteen core registers, 32 bits each
// - sram bit-band atomic access; unaligned support
`include "cpu_mode_defs.svh"

module cpu_mode_and_core_regs (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic [3:0]                rd_idx,
  input  wire logic                      rd_narrow,
  output cpu_mode_pkg::word_t            rd_data,
  input  wire logic                      wr_en,
  input  wire logic [3:0]                wr_idx,
  input  wire logic                      wr_narrow,
  input  wire cpu_mode_pkg::word_t       wr_data,
  input  wire logic                      call_en,
  input  wire cpu_mode_pkg::word_t       call_ret_addr,
  input  wire logic                      flags_en,
  input  wire logic [4:0]                flags_in,
  input  wire logic                      exc_entry,
  input  wire logic [8:0]                exc_num,
  input  wire logic                      exc_return,
  input  wire logic                      restricted_op,
  input  wire logic                      sys_wr_en,
  input  wire logic                      sys_rd_en,
  input  wire cpu_mode_pkg::sys_sel_e    sys_sel,
  input  wire cpu_mode_pkg::word_t       sys_wr_data,
  output cpu_mode_pkg::word_t            sys_rd_data,
  output logic                           fault,
  input  wire logic                      irq_req,
  input  wire logic [8:0]                irq_prio,
  input  wire logic                      irq_is_nmi,
  input  wire logic                      irq_is_hard_fault,
  output logic                           irq_pass,
  output logic                           handler_mode,
  output logic                           user_level,
  output logic                           process_stack_active,
  output cpu_mode_pkg::word_t            pc_out,
  input  wire logic                      bb_en,
  input  wire cpu_mode_pkg::word_t       bb_addr,
  input  wire logic                      bb_write,
  input  wire logic                      bb_bit_val,
  input  wire cpu_mode_pkg::word_t       bb_mem_word,
  output logic                           bb_hit,
  output cpu_mode_pkg::word_t            bb_word_addr,
  output cpu_mode_pkg::word_t            bb_new_word,
  output logic                           bb_rd_bit,
  input  wire logic [1:0]                ua_addr_lo,
  input  wire logic [1:0]                ua_size_m1,
  output logic                           ua_split,
  output logic [3:0]                     ua_first_be
);

  // ==========================================================
  // architectural state
  // ==========================================================
  cpu_mode_pkg::word_t general_regs [0:12];
  cpu_mode_pkg::word_t main_stack_ptr;
  cpu_mode_pkg::word_t process_stack_ptr;
  cpu_mode_pkg::word_t link_register;
  cpu_mode_pkg::word_t program_counter;
  logic [4:0]          app_flags;
  logic [8:0]          irq_status_view;
  cpu_mode_pkg::word_t exec_status_view;
  logic                general_int_mask;
  logic                fault_level_mask;
  logic [8:0]          priority_threshold;
  logic [1:0]          mode_select;
  logic                next_fault;
  logic                priv_sys_sel;
  logic                narrow_wr_block;
  logic                narrow_rd_block;
  logic                sys_write_ok;
  cpu_mode_pkg::word_t combined_status_word;
  cpu_mode_pkg::word_t active_sp;
  logic [5:0]          ua_span;

  assign user_level = !handler_mode && mode_select[`MODE_USER_BIT];
  // process pointer only for user thread
  assign process_stack_active = user_level &&
                                mode_select[`MODE_PSTK_BIT];
  assign active_sp = process_stack_active ? process_stack_ptr
                                          : main_stack_ptr;
  assign pc_out    = program_counter;

  // high registers out of reach of narrow forms
  assign narrow_wr_block = wr_narrow && wr_idx >= `IDX_HIGH_FIRST &&
                           wr_idx <= `IDX_HIGH_LAST;
  assign narrow_rd_block = rd_narrow && rd_idx >= `IDX_HIGH_FIRST &&
                           rd_idx <= `IDX_HIGH_LAST;

  assign combined_status_word =
    ({app_flags, 27'h000_0000} & `APP_MASK) |
    ({23'h00_0000, irq_status_view} & `IRQ_MASK) |
    (exec_status_view & `EXEC_MASK);

  assign priv_sys_sel = sys_sel == cpu_mode_pkg::sel_gen_mask ||
                        sys_sel == cpu_mode_pkg::sel_fault_mask ||
                        sys_sel == cpu_mode_pkg::sel_threshold ||
                        sys_sel == cpu_mode_pkg::sel_mode ||
                        sys_sel == cpu_mode_pkg::sel_exec;

  // user writes to mask, threshold, mode and exec registers refused
  assign sys_write_ok = sys_wr_en && !(user_level && priv_sys_sel);

  // ==========================================================
  // fault detection
  // ==========================================================
  always_comb begin
    next_fault = 1'b0;
    if (user_level && (restricted_op ||
        ((sys_wr_en || sys_rd_en) && priv_sys_sel)))
      next_fault = 1'b1;
    if (sys_wr_en && !user_level &&
        (sys_sel == cpu_mode_pkg::sel_exec ||
         sys_sel == cpu_mode_pkg::sel_combined) &&
        !sys_wr_data[`EXEC_STATE_BIT])
      next_fault = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      fault <= 1'b0;
    else
      fault <= next_fault;
  end

  // ==========================================================
  // mode and level
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (rst)
      handler_mode <= 1'b0;
    else if (exc_entry)
      handler_mode <= 1'b1;
    else if (exc_return)
      handler_mode <= 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      mode_select <= `MODE_RST;
    else if (sys_write_ok && sys_sel == cpu_mode_pkg::sel_mode) begin
      mode_select[`MODE_USER_BIT] <= sys_wr_data[`MODE_USER_BIT];
      // stack select written as zero when written in handler
      mode_select[`MODE_PSTK_BIT] <= !handler_mode &&
                                     sys_wr_data[`MODE_PSTK_BIT];
    end
  end

  // ==========================================================
  // mask registers
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      general_int_mask   <= 1'b0;
      fault_level_mask   <= 1'b0;
      priority_threshold <= `THRESH_RST;
    end else if (sys_write_ok) begin
      if (sys_sel == cpu_mode_pkg::sel_gen_mask)
        general_int_mask <= sys_wr_data[0];
      if (sys_sel == cpu_mode_pkg::sel_fault_mask)
        fault_level_mask <= sys_wr_data[0];
      if (sys_sel == cpu_mode_pkg::sel_threshold)
        priority_threshold <= sys_wr_data[8:0];
    end
  end

  always_comb begin
    irq_pass = 1'b0;
    if (irq_req) begin
      if (irq_is_nmi)
        irq_pass = 1'b1;
      else if (fault_level_mask)
        irq_pass = 1'b0;
      else if (irq_is_hard_fault)
        irq_pass = 1'b1;
      else if (general_int_mask)
        irq_pass = 1'b0;
      else if (priority_threshold != `THRESH_RST &&
               irq_prio >= priority_threshold)
        irq_pass = 1'b0;
      else
        irq_pass = 1'b1;
    end
  end

  // ==========================================================
  // status views
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (rst)
      irq_status_view <= `IRQ_NUM_NONE;
    else if (exc_entry)
      irq_status_view <= exc_num;
    else if (exc_return)
      irq_status_view <= `IRQ_NUM_NONE;
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      app_flags <= 5'h00;
    else if (flags_en)
      app_flags <= flags_in;
    else if (sys_write_ok && (sys_sel == cpu_mode_pkg::sel_app ||
             sys_sel == cpu_mode_pkg::sel_combined))
      app_flags <= sys_wr_data[`FLAG_MSB:`FLAG_LSB];
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      exec_status_view <= 32'h0000_0000 | (32'h0000_0001 << 
                          `EXEC_STATE_BIT);
    // state bit may never clear
    // user writes to the combined word only reach the app flags
    else if (sys_write_ok && !next_fault && !user_level &&
             (sys_sel == cpu_mode_pkg::sel_exec ||
              sys_sel == cpu_mode_pkg::sel_combined))
      exec_status_view <= sys_wr_data & `EXEC_MASK;
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      sys_rd_data <= 32'h0000_0000;
    else if (sys_rd_en) begin
      case (sys_sel)
        cpu_mode_pkg::sel_combined:
          sys_rd_data <= combined_status_word;
        cpu_mode_pkg::sel_app:
          sys_rd_data <= combined_status_word & `APP_MASK;
        cpu_mode_pkg::sel_irq:
          sys_rd_data <= combined_status_word & `IRQ_MASK;
        cpu_mode_pkg::sel_exec:
          sys_rd_data <= user_level ? 32'h0000_0000 :
                         combined_status_word & `EXEC_MASK;
        cpu_mode_pkg::sel_gen_mask:
          sys_rd_data <= {31'h0000_0000, general_int_mask};
        cpu_mode_pkg::sel_fault_mask:
          sys_rd_data <= {31'h0000_0000, fault_level_mask};
        cpu_mode_pkg::sel_threshold:
          sys_rd_data <= {23'h00_0000, priority_threshold};
        cpu_mode_pkg::sel_mode:
          sys_rd_data <= {30'h0000_0000, mode_select};
        default:
          sys_rd_data <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // core registers
  // ==========================================================
  // thirteen general words
  for (genvar g = 0; g < 13; g++) begin : g_gpr
    always_ff @(posedge clk_sys) begin
      if (rst)
        general_regs[g] <= 32'h0000_0000;
      else if (wr_en && !narrow_wr_block && wr_idx == 4'(g))
        general_regs[g] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      main_stack_ptr    <= 32'h0000_0000;
      process_stack_ptr <= 32'h0000_0000;
    end else if (wr_en && wr_idx == `IDX_SP) begin
      if (process_stack_active)
        process_stack_ptr <= wr_data & `SP_ALIGN_MASK;
      else
        main_stack_ptr <= wr_data & `SP_ALIGN_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      link_register <= 32'h0000_0000;
    else if (call_en)
      link_register <= call_ret_addr;
    else if (wr_en && wr_idx == `IDX_LR)
      link_register <= wr_data;
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      program_counter <= 32'h0000_0000;
    else if (wr_en && wr_idx == `IDX_PC)
      program_counter <= wr_data & `PC_ALIGN_MASK;
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      rd_data <= 32'h0000_0000;
    else if (narrow_rd_block)
      rd_data <= 32'h0000_0000;
    else if (rd_idx == `IDX_SP)
      rd_data <= active_sp;
    else if (rd_idx == `IDX_LR)
      rd_data <= link_register;
    else if (rd_idx == `IDX_PC)
      rd_data <= program_counter;
    else
      rd_data <= general_regs[rd_idx];
  end

  // ==========================================================
  // bit-band and unaligned helpers
  // ==========================================================
  // one cycle read-modify-write keeps the bit update atomic
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bb_hit       <= 1'b0;
      bb_word_addr <= 32'h0000_0000;
      bb_new_word  <= 32'h0000_0000;
      bb_rd_bit    <= 1'b0;
    end else if (bb_en) begin
      // alias word maps to one sram bit
      bb_hit <= bb_addr >= `BB_ALIAS_BASE &&
                bb_addr < `BB_ALIAS_BASE + `BB_ALIAS_SPAN;
      bb_word_addr <= `BB_SRAM_BASE + (((bb_addr - `BB_ALIAS_BASE)
                      >> `BB_WORD_SHIFT) & `SP_ALIGN_MASK);
      bb_rd_bit <= bb_mem_word[bb_addr[6:2]];
      if (bb_write)
        bb_new_word <= (bb_mem_word &
                        ~(32'h0000_0001 << bb_addr[6:2])) |
                       ({31'h0000_0000, bb_bit_val} << bb_addr[6:2]);
      else
        bb_new_word <= bb_mem_word;
    end
  end

  assign ua_span = 6'(ua_addr_lo) + 6'(ua_size_m1);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ua_split    <= 1'b0;
      ua_first_be <= 4'h0;
    end else begin
      ua_split    <= ua_span > 6'h03;
      ua_first_be <= 4'((5'h0f >> (2'h3 - ua_size_m1)) << ua_addr_lo);
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  a_no_user_handler: assert property (@(posedge clk_sys)
    disable iff (rst) handler_mode |-> !user_level)
    else $error("user level seen in handler mode");

  a_user_mask_fault: assert property (@(posedge clk_sys)
    disable iff (rst) (sys_wr_en && user_level &&
      sys_sel == cpu_mode_pkg::sel_gen_mask) |=>
      fault && $stable(general_int_mask))
    else $error("user mask write not refused");

  a_entry_handler: assert property (@(posedge clk_sys)
    disable iff (rst) (exc_entry && !exc_return) |=>
      handler_mode && !user_level && !process_stack_active)
    else $error("exception entry not in privileged handler");

  a_sp_aligned: assert property (@(posedge clk_sys)
    disable iff (rst) active_sp[1:0] == 2'h0)
    else $error("stack pointer misaligned");

  a_pc_aligned: assert property (@(posedge clk_sys)
    disable iff (rst) (wr_en && wr_idx == `IDX_PC) |=>
      program_counter == ($past(wr_data) & `PC_ALIGN_MASK))
    else $error("program counter bit zero not cleared");

  a_link_on_call: assert property (@(posedge clk_sys)
    disable iff (rst) call_en |=> link_register == $past(call_ret_addr))
    else $error("link register missed return address");

  a_irq_number: assert property (@(posedge clk_sys)
    disable iff (rst) (exc_entry ##1 !exc_entry && !exc_return) |=>
      irq_status_view == $past(exc_num, 2))
    else $error("exception number not held");

  a_state_bit: assert property (@(posedge clk_sys)
    disable iff (rst) exec_status_view[`EXEC_STATE_BIT])
    else $error("execution state bit cleared");

  a_gen_mask: assert property (@(posedge clk_sys)
    disable iff (rst) (general_int_mask && !irq_is_nmi &&
      !irq_is_hard_fault) |-> !irq_pass)
    else $error("general mask let interrupt through");

  a_fault_mask: assert property (@(posedge clk_sys)
    disable iff (rst) (irq_req && irq_is_nmi) |-> irq_pass)
    else $error("nmi was masked");

  a_fault_mask_block: assert property (@(posedge clk_sys)
    disable iff (rst) (fault_level_mask && !irq_is_nmi) |-> !irq_pass)
    else $error("fault mask let interrupt through");

  a_threshold: assert property (@(posedge clk_sys)
    disable iff (rst) (priority_threshold != 9'h000 && !irq_is_nmi &&
      !irq_is_hard_fault && irq_prio >= priority_threshold) |-> !irq_pass)
    else $error("threshold did not block interrupt");

  a_handler_stack: assert property (@(posedge clk_sys)
    disable iff (rst) (handler_mode && sys_write_ok &&
      sys_sel == cpu_mode_pkg::sel_mode) |=> !mode_select[1])
    else $error("process stack chosen in handler");

  a_narrow_block: assert property (@(posedge clk_sys)
    disable iff (rst) (rd_narrow && rd_idx == 4'h9) |=> rd_data == 0)
    else $error("narrow read reached high register");

  a_reset_state: assert property (@(posedge clk_sys)
    $past(rst) |-> !handler_mode && !user_level &&
      !general_int_mask && !fault_level_mask &&
      priority_threshold == 9'h000)
    else $error("wrong state after reset");

endmodule // cpu_mode_and_core_regs

// file: dv/test_cpu_mode_and_core_regs.sv
module test_cpu_mode_and_core_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // stimulus and observed signals
  logic                      clk_sys, rst;
  logic [3:0]                rd_idx, wr_idx;
  logic                      rd_narrow, wr_en, wr_narrow, call_en, flags_en;
  cpu_mode_pkg::word_t       rd_data, wr_data, call_ret_addr;
  logic [4:0]                flags_in;
  logic                      exc_entry, exc_return, restricted_op;
  logic [8:0]                exc_num, irq_prio;
  logic                      sys_wr_en, sys_rd_en;
  cpu_mode_pkg::sys_sel_e    sys_sel;
  cpu_mode_pkg::word_t       sys_wr_data, sys_rd_data, pc_out;
  logic                      fault, irq_req, irq_is_nmi, irq_is_hard_fault;
  logic                      irq_pass, handler_mode, user_level;
  logic                      process_stack_active;
  logic                      bb_en, bb_write, bb_bit_val, bb_hit, bb_rd_bit;
  cpu_mode_pkg::word_t       bb_addr, bb_mem_word, bb_word_addr, bb_new_word;
  logic [1:0]                ua_addr_lo, ua_size_m1;
  logic                      ua_split;
  logic [3:0]                ua_first_be;
  int                        n_fail, check_count;
  int                        cycle_cnt = 0;
  cpu_mode_pkg::word_t       v;

  cpu_mode_and_core_regs uut (.*);

  // ==========================================================
  // clock, timeout and verdict
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole run needs under a hundred cycles; generous ceiling
  always @(posedge clk_sys) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt >= 5000) begin
      n_fail++;
      conclude();
    end
  end

  // ==========================================================
  // compare and access tasks
  task automatic chk_w(string what, cpu_mode_pkg::word_t exp,
                       cpu_mode_pkg::word_t got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_b(string what, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic tick();
    @(negedge clk_sys);
  endtask

  task automatic reg_wr(logic [3:0] idx, cpu_mode_pkg::word_t d, logic nw);
    wr_idx = idx;
    wr_data = d;
    wr_narrow = nw;
    wr_en = 1'b1;
    tick();
    wr_en = 1'b0;
  endtask

  task automatic reg_rd(logic [3:0] idx, logic nw,
                        output cpu_mode_pkg::word_t d);
    rd_idx = idx;
    rd_narrow = nw;
    tick();
    d = rd_data;
  endtask

  task automatic sys_wr(cpu_mode_pkg::sys_sel_e s, cpu_mode_pkg::word_t d);
    sys_sel = s;
    sys_wr_data = d;
    sys_wr_en = 1'b1;
    tick();
    sys_wr_en = 1'b0;
  endtask

  task automatic sys_rd(cpu_mode_pkg::sys_sel_e s,
                        output cpu_mode_pkg::word_t d);
    sys_sel = s;
    sys_rd_en = 1'b1;
    tick();
    sys_rd_en = 1'b0;
    d = sys_rd_data;
  endtask

  task automatic irq_chk(logic nmi, logic hf, logic [8:0] pr, logic exp);
    irq_is_nmi = nmi;
    irq_is_hard_fault = hf;
    irq_prio = pr;
    irq_req = 1'b1;
    // a full cycle keeps every later drive on the falling edge
    tick();
    chk_b("irq_pass", exp, irq_pass);
  endtask

  task automatic exc(logic entry, logic [8:0] num);
    exc_entry = entry;
    exc_return = ~entry;
    exc_num = num;
    tick();
    exc_entry = 1'b0;
    exc_return = 1'b0;
  endtask

  // ==========================================================
  // scenarios
  // reset state
  task automatic t_reset();
    chk_b("handler_mode", 1'b0, handler_mode);
    chk_b("user_level", 1'b0, user_level);
    chk_b("psa", 1'b0, process_stack_active);
    sys_rd(cpu_mode_pkg::sel_exec, v);
    chk_w("exec", 32'h0100_0000, v);
    irq_chk(1'b0, 1'b0, 9'h001, 1'b1);
  endtask

  task automatic t_regs();
    reg_wr(4'h0, 32'hffff_ffff, 1'b0);
    reg_rd(4'h0, 1'b1, v);
    chk_w("r0", 32'hffff_ffff, v);
    reg_wr(4'hd, 32'h1234_5677, 1'b0);
    reg_rd(4'hd, 1'b0, v);
    chk_w("sp", 32'h1234_5674, v);
    reg_wr(4'hf, 32'h0000_0005, 1'b0);
    chk_w("pc_out", 32'h0000_0004, pc_out);
    tick();
    reg_wr(4'h8, 32'h0000_abcd, 1'b0);
    tick();
    reg_wr(4'h8, 32'h0000_1111, 1'b1);
    reg_rd(4'h8, 1'b1, v);
    chk_w("r8 narrow", 32'h0000_0000, v);
    reg_rd(4'h8, 1'b0, v);
    chk_w("r8 wide", 32'h0000_abcd, v);
    reg_wr(4'h7, 32'h0000_0077, 1'b1);
    reg_rd(4'h7, 1'b1, v);
    chk_w("r7 narrow", 32'h0000_0077, v);
  endtask

  task automatic t_status();
    call_ret_addr = 32'h0000_1235;
    call_en = 1'b1;
    tick();
    call_en = 1'b0;
    reg_rd(4'he, 1'b0, v);
    chk_w("link", 32'h0000_1235, v);
    flags_in = 5'h15;
    flags_en = 1'b1;
    tick();
    flags_en = 1'b0;
    sys_rd(cpu_mode_pkg::sel_app, v);
    chk_w("app", 32'ha800_0000, v);
    tick();
    sys_rd(cpu_mode_pkg::sel_combined, v);
    chk_w("combined", 32'ha900_0000, v);
    sys_wr(cpu_mode_pkg::sel_exec, 32'h0000_0000);
    chk_b("fault", 1'b1, fault);
    sys_rd(cpu_mode_pkg::sel_exec, v);
    chk_w("exec kept", 32'h0100_0000, v);
  endtask

  task automatic t_masks();
    sys_wr(cpu_mode_pkg::sel_gen_mask, 32'h0000_0001);
    irq_chk(1'b1, 1'b0, 9'h005, 1'b1);
    irq_chk(1'b0, 1'b1, 9'h005, 1'b1);
    irq_chk(1'b0, 1'b0, 9'h005, 1'b0);
    sys_wr(cpu_mode_pkg::sel_gen_mask, 32'h0000_0000);
    tick();
    sys_wr(cpu_mode_pkg::sel_fault_mask, 32'h0000_0001);
    irq_chk(1'b1, 1'b0, 9'h005, 1'b1);
    irq_chk(1'b0, 1'b1, 9'h005, 1'b0);
    sys_wr(cpu_mode_pkg::sel_fault_mask, 32'h0000_0000);
    tick();
    sys_wr(cpu_mode_pkg::sel_threshold, 32'h0000_0004);
    irq_chk(1'b0, 1'b0, 9'h004, 1'b0);
    irq_chk(1'b0, 1'b0, 9'h005, 1'b0);
    irq_chk(1'b0, 1'b0, 9'h003, 1'b1);
    sys_wr(cpu_mode_pkg::sel_threshold, 32'h0000_0000);
    irq_chk(1'b0, 1'b0, 9'h000, 1'b1);
  endtask

  task automatic t_modes();
    restricted_op = 1'b1;
    tick();
    restricted_op = 1'b0;
    chk_b("fault priv", 1'b0, fault);
    sys_wr(cpu_mode_pkg::sel_mode, 32'h0000_0003);
    chk_b("user_level", 1'b1, user_level);
    chk_b("psa", 1'b1, process_stack_active);
    reg_wr(4'hd, 32'h0000_4003, 1'b0);
    reg_rd(4'hd, 1'b0, v);
    chk_w("psp", 32'h0000_4000, v);
    sys_wr(cpu_mode_pkg::sel_gen_mask, 32'h0000_0001);
    chk_b("fault user", 1'b1, fault);
    irq_chk(1'b0, 1'b0, 9'h005, 1'b1);
    restricted_op = 1'b1;
    tick();
    restricted_op = 1'b0;
    chk_b("fault op", 1'b1, fault);
    sys_wr(cpu_mode_pkg::sel_combined, 32'h0000_0000);
    sys_rd(cpu_mode_pkg::sel_combined, v);
    chk_w("user combined", 32'h0100_0000, v);
    exc(1'b1, 9'h00b);
    chk_b("handler", 1'b1, handler_mode);
    chk_b("user in handler", 1'b0, user_level);
    chk_b("psa handler", 1'b0, process_stack_active);
    reg_rd(4'hd, 1'b0, v);
    chk_w("msp", 32'h1234_5674, v);
    sys_rd(cpu_mode_pkg::sel_irq, v);
    chk_w("irq view", 32'h0000_000b, v);
    sys_wr(cpu_mode_pkg::sel_mode, 32'h0000_0002);
    sys_rd(cpu_mode_pkg::sel_mode, v);
    chk_w("mode handler", 32'h0000_0000, v);
    exc(1'b0, 9'h000);
    chk_b("thread", 1'b0, handler_mode);
    chk_b("priv thread", 1'b0, user_level);
    sys_rd(cpu_mode_pkg::sel_irq, v);
    chk_w("irq none", 32'h0000_0000, v);
  endtask

  task automatic t_bitband();
    bb_addr = 32'h2200_020c;
    bb_write = 1'b1;
    bb_bit_val = 1'b1;
    bb_mem_word = 32'h0000_0000;
    bb_en = 1'b1;
    tick();
    chk_b("bb_hit", 1'b1, bb_hit);
    chk_w("bb_word_addr", 32'h2000_0010, bb_word_addr);
    chk_w("bb_new_word", 32'h0000_0008, bb_new_word);
    bb_write = 1'b0;
    bb_mem_word = 32'h0000_0008;
    tick();
    bb_en = 1'b0;
    chk_b("bb_rd_bit", 1'b1, bb_rd_bit);
    ua_addr_lo = 2'h3;
    ua_size_m1 = 2'h1;
    tick();
    chk_b("ua_split", 1'b1, ua_split);
    chk_w("ua_be", 32'h0000_0008, {28'h000_0000, ua_first_be});
    ua_addr_lo = 2'h0;
    ua_size_m1 = 2'h3;
    tick();
    chk_b("ua_split al", 1'b0, ua_split);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    n_fail = 0;
    check_count = 0;
    rst = 1'b1;
    {rd_idx, wr_idx, rd_narrow, wr_en, wr_narrow, call_en, flags_en} = '0;
    {wr_data, call_ret_addr, flags_in, exc_num, irq_prio} = '0;
    {exc_entry, exc_return, restricted_op, sys_wr_en, sys_rd_en} = '0;
    sys_sel = cpu_mode_pkg::sel_combined;
    sys_wr_data = 32'h0000_0000;
    {irq_req, irq_is_nmi, irq_is_hard_fault, bb_en, bb_write} = '0;
    {bb_bit_val, bb_addr, bb_mem_word, ua_addr_lo, ua_size_m1} = '0;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_status();
    t_masks();
    t_modes();
    t_bitband();
    conclude();
  end
endmodule // test_cpu_mode_and_core_regs
